//--- src/rssd_pkg.sv
package rssd_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int REG_ADR_W = 4;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [REG_ADR_W-1:0] REG_WORK_OFS  = 4'h0;
  localparam logic [REG_ADR_W-1:0] REG_FLAGS_OFS = 4'h4;
  localparam logic [DATA_W-1:0]    WORK_RST      = 8'h00;
  localparam logic [DATA_W-1:0]    ONE_BYTE      = 8'h01;

  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    rotate_right_thru_carry_to_work,
    subtract_with_borrow_to_work,
    subtract_with_borrow_imm_to_work,
    subtract_with_borrow_to_memory,
    decrement_skip_if_null,
    decrement_to_work_skip_if_null
  } op_t;

  // flag register layout, bit 5 down to bit 0; upper bits read zero
  typedef struct packed {
    logic signed_range_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
    logic extra_flag_one;
    logic extra_flag_two;
  } flags_t;

  localparam int     FLAGS_W   = $bits(flags_t);
  localparam flags_t FLAGS_RST = '0;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] literal;
  } request_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_DUMMY
  } step_t;

endpackage : rssd_pkg

//--- src/rotate_subtract_skip_datapath.sv
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Contract
// - rotate: work[i] gets memory[i+1], work[7] old carry, carry gets memory bit 0.
// - rotate through carry leaves the memory byte untouched; only work and carry change.
// - memory-operand subtract: work minus memory minus inverted carry, result to work.
// - immediate subtract: work minus literal minus inverted carry, result to work.
// - subtract to memory: result written to memory byte, work register unchanged.
// - subtracts clear carry on negative result, set it on zero or positive.
// - subtracts update range, zero, half-carry, carry and both extra flags.
// - decrement skip: memory byte minus one written back, skip next when zero.
// - taken skip inserts one dummy cycle, so the instruction takes three cycles instead of two.
// - nonzero decrement result continues with next instruction, no skip.
// - decrement to work: memory minus one into work, memory kept, skip when zero.
module rotate_subtract_skip_datapath (
  input  wire logic                                clock_i,
  input  wire logic                                rst_i,
  input  wire logic                                req_valid_i,
  input  wire rssd_pkg::request_t                  req_i,
  output logic                                     ready_o,
  output logic                                     done_o,
  output logic                                     skip_o,
  output logic                                     mem_rd_o,
  output logic [rssd_pkg::ADDR_W-1:0]              mem_addr_o,
  input  wire logic [rssd_pkg::DATA_W-1:0]         mem_rd_data_i,
  output logic                                     mem_wr_o,
  output logic [rssd_pkg::DATA_W-1:0]              mem_wr_data_o,
  input  wire logic [rssd_pkg::REG_ADR_W-1:0]      reg_addr_i,
  input  wire logic [rssd_pkg::DATA_W-1:0]         reg_wdata_i,
  input  wire logic                                reg_wr_i,
  input  wire logic                                reg_rd_i,
  output logic [rssd_pkg::DATA_W-1:0]              reg_rdata_o,
  output logic [rssd_pkg::DATA_W-1:0]              work_o,
  output rssd_pkg::flags_t                         flags_o
);
  import rssd_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    step_t             step;
    request_t          req;
    logic [DATA_W-1:0] work;
    flags_t            flags;
    logic              done;
    logic              skip;
    logic              mem_rd;
    logic              mem_wr;
    logic [DATA_W-1:0] mem_wr_data;
    logic [DATA_W-1:0] rdata;
  } core_t;

  core_t state_ff;
  core_t nxt_state;

  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  function automatic logic is_subtract(input op_t op);
    return (op == subtract_with_borrow_to_work) || (op == subtract_with_borrow_imm_to_work) ||
           (op == subtract_with_borrow_to_memory);
  endfunction : is_subtract

  function automatic logic is_decrement(input op_t op);
    return (op == decrement_skip_if_null) || (op == decrement_to_work_skip_if_null);
  endfunction : is_decrement

  logic [DATA_W-1:0] sub_operand;
  logic [DATA_W:0]   sub_sum;
  logic [4:0]        nib_sum;
  logic [DATA_W-1:0] sub_result;
  logic [DATA_W-1:0] dec_result;
  logic              sub_ovf;
  flags_t            sub_flags;

  // subtract as work + ~operand + carry: carry out high means no borrow
  always_comb begin
    sub_operand = (state_ff.req.op == subtract_with_borrow_imm_to_work) ? state_ff.req.literal
                                                                         : mem_rd_data_i;
    sub_sum     = {1'b0, state_ff.work} + {1'b0, ~sub_operand} + {8'h00, state_ff.flags.carry_flag};
    nib_sum     = {1'b0, state_ff.work[3:0]} + {1'b0, ~sub_operand[3:0]}
                  + {4'h0, state_ff.flags.carry_flag};
    sub_result  = sub_sum[DATA_W-1:0];
    sub_ovf     = (state_ff.work[DATA_W-1] != sub_operand[DATA_W-1]) &&
                  (sub_result[DATA_W-1] != state_ff.work[DATA_W-1]);
    sub_flags.signed_range_flag = sub_ovf;
    sub_flags.zero_flag         = (sub_result == 8'h00);
    sub_flags.half_carry_flag   = nib_sum[4];
    sub_flags.carry_flag        = sub_sum[DATA_W];
    // signed less-than, and a zero that chains across multi-byte subtracts
    sub_flags.extra_flag_one    = sub_result[DATA_W-1] ^ sub_ovf;
    sub_flags.extra_flag_two    = (sub_result == 8'h00) && state_ff.flags.extra_flag_two;
    dec_result  = mem_rd_data_i - ONE_BYTE;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.done   = 1'b0;
    nxt_state.skip   = 1'b0;
    nxt_state.mem_rd = 1'b0;
    nxt_state.mem_wr = 1'b0;
    nxt_state.rdata  = 8'h00;

    // software access; an executing instruction overrides a same-cycle write, except work during decrement_skip_if_null and non-carry flags during a rotate
    if (reg_wr_i) begin
      if (reg_addr_i == REG_WORK_OFS) begin
        nxt_state.work = reg_wdata_i;
      end else if (reg_addr_i == REG_FLAGS_OFS) begin
        nxt_state.flags = reg_wdata_i[FLAGS_W-1:0];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == REG_WORK_OFS) begin
        nxt_state.rdata = state_ff.work;
      end else if (reg_addr_i == REG_FLAGS_OFS) begin
        nxt_state.rdata = {2'b00, state_ff.flags};
      end
    end

    case (state_ff.step)
      ST_IDLE: begin
        if (req_valid_i) begin
          nxt_state.req    = req_i;
          nxt_state.mem_rd = 1'b1;
          nxt_state.step   = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // memory answers one cycle after the read strobe
        nxt_state.step = ST_EXEC;
      end
      ST_EXEC: begin
        nxt_state.done = 1'b1;
        nxt_state.step = ST_IDLE;
        case (state_ff.req.op)
          rotate_right_thru_carry_to_work: begin
            nxt_state.work                = {state_ff.flags.carry_flag, mem_rd_data_i[DATA_W-1:1]};
            nxt_state.flags.carry_flag    = mem_rd_data_i[0];
          end
          subtract_with_borrow_to_work,
          subtract_with_borrow_imm_to_work: begin
            nxt_state.work  = sub_result;
            nxt_state.flags = sub_flags;
          end
          subtract_with_borrow_to_memory: begin
            nxt_state.mem_wr      = 1'b1;
            nxt_state.mem_wr_data = sub_result;
            nxt_state.work        = state_ff.work;
            nxt_state.flags       = sub_flags;
          end
          decrement_skip_if_null: begin
            nxt_state.mem_wr      = 1'b1;
            nxt_state.mem_wr_data = dec_result;
            nxt_state.flags       = state_ff.flags;
            nxt_state.skip        = (dec_result == 8'h00);
            nxt_state.step        = (dec_result == 8'h00) ? ST_DUMMY : ST_IDLE;
          end
          decrement_to_work_skip_if_null: begin
            nxt_state.work  = dec_result;
            nxt_state.flags = state_ff.flags;
            nxt_state.skip  = (dec_result == 8'h00);
            nxt_state.step  = (dec_result == 8'h00) ? ST_DUMMY : ST_IDLE;
          end
          default: begin
            nxt_state.done = 1'b1;
          end
        endcase
      end
      ST_DUMMY: begin
        // dummy slot while the skipped instruction is fetched and dropped
        nxt_state.step = ST_IDLE;
      end
      default: begin
        nxt_state.step = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '{step: ST_IDLE, req: '0, work: WORK_RST, flags: FLAGS_RST, done: 1'b0, skip: 1'b0,
                    mem_rd: 1'b0, mem_wr: 1'b0, mem_wr_data: 8'h00, rdata: 8'h00};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ready_o       = (state_ff.step == ST_IDLE);
  assign done_o        = state_ff.done;
  assign skip_o        = state_ff.skip;
  assign mem_rd_o      = state_ff.mem_rd;
  assign mem_addr_o    = state_ff.req.addr;
  assign mem_wr_o      = state_ff.mem_wr;
  assign mem_wr_data_o = state_ff.mem_wr_data;
  assign reg_rdata_o   = state_ff.rdata;
  assign work_o        = state_ff.work;
  assign flags_o       = state_ff.flags;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // a same-cycle register write loses to the result, except for the fields named at the software access; left out so the checks stay simple
  logic exec_now;
  assign exec_now = (state_ff.step == ST_EXEC) && !reg_wr_i;

  a_rotate_result: assert property (
    exec_now && state_ff.req.op == rotate_right_thru_carry_to_work |=>
      work_o == {$past(flags_o.carry_flag), $past(mem_rd_data_i[7:1])} &&
      flags_o.carry_flag == $past(mem_rd_data_i[0]))
    else $error("rotate result or carry wrong");

  a_rotate_no_write: assert property (
    state_ff.step == ST_EXEC && state_ff.req.op == rotate_right_thru_carry_to_work |=> !mem_wr_o)
    else $error("rotate wrote memory");

  a_sub_mem_work: assert property (
    exec_now && state_ff.req.op == subtract_with_borrow_to_work |=>
      work_o == $past(work_o - mem_rd_data_i - {7'h00, !flags_o.carry_flag}))
    else $error("memory subtract result wrong");

  a_sub_imm_work: assert property (
    exec_now && state_ff.req.op == subtract_with_borrow_imm_to_work |=>
      work_o == $past(work_o - state_ff.req.literal - {7'h00, !flags_o.carry_flag}))
    else $error("immediate subtract result wrong");

  a_sub_to_mem: assert property (
    exec_now && state_ff.req.op == subtract_with_borrow_to_memory |=>
      mem_wr_o && $stable(work_o) &&
      mem_wr_data_o == $past(work_o - mem_rd_data_i - {7'h00, !flags_o.carry_flag}))
    else $error("subtract to memory wrong");

  a_sub_carry: assert property (
    exec_now && is_subtract(state_ff.req.op) |=>
      flags_o.carry_flag == ($past({1'b0, work_o}) >= $past({1'b0, sub_operand} + {8'h00, !flags_o.carry_flag})))
    else $error("subtract carry wrong");

  a_sub_zero: assert property (
    exec_now && is_subtract(state_ff.req.op) |=>
      flags_o.zero_flag == ($past(work_o - sub_operand - {7'h00, !flags_o.carry_flag}) == 8'h00) &&
      flags_o.signed_range_flag == $past(sub_ovf))
    else $error("subtract flags wrong");

  a_dec_mem: assert property (
    state_ff.step == ST_EXEC && state_ff.req.op == decrement_skip_if_null |=>
      mem_wr_o && mem_wr_data_o == $past(mem_rd_data_i) - 8'h01)
    else $error("decrement write wrong");

  a_skip_dummy: assert property (
    state_ff.step == ST_EXEC && is_decrement(state_ff.req.op) && mem_rd_data_i == 8'h01 |=>
      skip_o && !ready_o ##1 !skip_o && ready_o)
    else $error("skip without dummy cycle");

  a_no_skip: assert property (
    state_ff.step == ST_EXEC && is_decrement(state_ff.req.op) && mem_rd_data_i != 8'h01 |=>
      !skip_o && ready_o)
    else $error("skip taken on nonzero");

  a_dec_work: assert property (
    exec_now && state_ff.req.op == decrement_to_work_skip_if_null |=>
      !mem_wr_o && work_o == $past(mem_rd_data_i) - 8'h01)
    else $error("decrement to work wrong");

  a_flags_kept: assert property (
    exec_now && (is_decrement(state_ff.req.op) || state_ff.req.op == rotate_right_thru_carry_to_work) |=>
      flags_o.zero_flag == $past(flags_o.zero_flag) &&
      flags_o.half_carry_flag == $past(flags_o.half_carry_flag) &&
      flags_o.signed_range_flag == $past(flags_o.signed_range_flag) &&
      {flags_o.extra_flag_one, flags_o.extra_flag_two} == $past({flags_o.extra_flag_one, flags_o.extra_flag_two}))
    else $error("flags altered");

  a_sub_half: assert property (
    exec_now && is_subtract(state_ff.req.op) |=>
      flags_o.half_carry_flag ==
        ($past({1'b0, work_o[3:0]}) >= $past({1'b0, sub_operand[3:0]} + {4'h0, !flags_o.carry_flag})))
    else $error("subtract half carry wrong");

  a_fetch_read: assert property (
    ready_o && req_valid_i |=> mem_rd_o && !ready_o ##1 !mem_rd_o && !ready_o)
    else $error("operand fetch wrong");

  a_dec_work_kept: assert property (
    exec_now && state_ff.req.op == decrement_skip_if_null |=> $stable(work_o))
    else $error("decrement to memory changed work");

  a_skip_with_done: assert property (
    skip_o |-> done_o)
    else $error("skip without done");

  a_done_pulse: assert property (
    done_o |=> !done_o)
    else $error("done longer than one cycle");

endmodule : rotate_subtract_skip_datapath

//--- dv/data_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// data memory partner, one cycle read latency
// ----------------------------------------
module data_mem_model (
  input  wire logic                          clock_i,
  input  wire logic                          rd_i,
  input  wire logic [rssd_pkg::ADDR_W-1:0]   addr_i,
  output logic      [rssd_pkg::DATA_W-1:0]   rd_data_o,
  input  wire logic                          wr_i,
  input  wire logic [rssd_pkg::DATA_W-1:0]   wr_data_i
);
  import rssd_pkg::*;
  logic [DATA_W-1:0] mem_ff [256];
  // byte stands in the cycle after the read, then is inverted each cycle, so the stale byte returns every second cycle
  always @(posedge clock_i) begin
    if (rd_i) begin
      rd_data_o <= mem_ff[addr_i];
    end else begin
      rd_data_o <= ~rd_data_o;
    end
    if (wr_i) begin
      mem_ff[addr_i] <= wr_data_i;
    end
  end
endmodule : data_mem_model

//--- dv/rotate_subtract_skip_datapath_tb.sv
`timescale 1ns/1ps
module rotate_subtract_skip_datapath_tb;
  import rssd_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid = 1'b0;
  request_t req = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ready_o, done_o, skip_o, mem_rd, mem_wr;
  logic [7:0] mem_addr, mem_rdata, mem_wdata, reg_rdata_o, work_o;
  flags_t flags_o;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] rv;

  always #12.5 clock_i = ~clock_i;

  rotate_subtract_skip_datapath dut_u (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid),
    .req_i(req), .ready_o(ready_o), .done_o(done_o), .skip_o(skip_o), .mem_rd_o(mem_rd),
    .mem_addr_o(mem_addr), .mem_rd_data_i(mem_rdata), .mem_wr_o(mem_wr), .mem_wr_data_o(mem_wdata),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata_o), .work_o(work_o), .flags_o(flags_o));

  data_mem_model mem_u (.clock_i(clock_i), .rd_i(mem_rd), .addr_i(mem_addr), .rd_data_o(mem_rdata),
    .wr_i(mem_wr), .wr_data_i(mem_wdata));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // longest path is under two hundred cycles; a hang stops here
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  task automatic reg_write(input logic [3:0] ra, input logic [7:0] wd);
    @(posedge clock_i);
    reg_wr <= 1'b1;
    reg_addr <= ra;
    reg_wdata <= wd;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] ra, output logic [7:0] v);
    @(posedge clock_i);
    reg_rd <= 1'b1;
    reg_addr <= ra;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    @(negedge clock_i);
    v = reg_rdata_o;
  endtask : reg_read

  // ----------------------------------------
  // one instruction with preset work, flags and byte
  // ----------------------------------------
  task automatic run(input op_t op, input logic [7:0] a, lit, m, w, input logic [5:0] f);
    logic [8:0] r9;
    logic [4:0] h5;
    logic [7:0] ew, em, opnd;
    flags_t ef;
    logic es;
    opnd = (op == subtract_with_borrow_imm_to_work) ? lit : m;
    r9 = {1'b0, w} - {1'b0, opnd} - {8'h00, ~f[2]};
    h5 = {1'b0, w[3:0]} - {1'b0, opnd[3:0]} - {4'h0, ~f[2]};
    ef = f;
    ew = w;
    em = m;
    es = 1'b0;
    case (op)
      rotate_right_thru_carry_to_work: begin
        ew = {f[2], m[7:1]};
        ef.carry_flag = m[0];
      end
      decrement_skip_if_null: begin
        em = m - ONE_BYTE;
        es = (em == 8'h00);
      end
      decrement_to_work_skip_if_null: begin
        ew = m - ONE_BYTE;
        es = (ew == 8'h00);
      end
      default: begin
        if (op == subtract_with_borrow_to_memory) em = r9[7:0];
        else ew = r9[7:0];
        ef.carry_flag = ~r9[8];
        ef.zero_flag = (r9[7:0] == 8'h00);
        ef.half_carry_flag = ~h5[4];
        ef.signed_range_flag = (w[7] != opnd[7]) && (r9[7] != w[7]);
        ef.extra_flag_one = r9[7] ^ ef.signed_range_flag;
        ef.extra_flag_two = ef.zero_flag & f[0];
      end
    endcase
    reg_write(REG_WORK_OFS, w);
    reg_write(REG_FLAGS_OFS, {2'b00, f});
    mem_u.mem_ff[a] = m;
    @(posedge clock_i);
    req_valid <= 1'b1;
    req <= '{op, a, lit};
    do @(negedge clock_i);
    while (ready_o !== 1'b1);
    @(posedge clock_i);
    req_valid <= 1'b0;
    do @(negedge clock_i);
    while (done_o !== 1'b1);
    check("skip", {7'h00, skip_o}, {7'h00, es});
    check("ready_in_done", {7'h00, ready_o}, {7'h00, ~es});
    @(negedge clock_i);
    check("ready_after", {7'h00, ready_o}, 8'h01);
    check("work", work_o, ew);
    check("flags", {2'b00, flags_o}, {2'b00, ef});
    check("mem", mem_u.mem_ff[a], em);
  endtask : run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("rst_ready", {7'h00, ready_o}, 8'h01);
    check("rst_skip", {7'h00, skip_o}, 8'h00);
    check("rst_work", work_o, WORK_RST);
    check("rst_flags", {2'b00, flags_o}, {2'b00, FLAGS_RST});
    run(rotate_right_thru_carry_to_work, 8'h10, 8'h00, 8'hA5, 8'h00, 6'h3F);
    run(rotate_right_thru_carry_to_work, 8'h11, 8'h00, 8'h4A, 8'hFF, 6'h00);
    run(subtract_with_borrow_to_work, 8'h20, 8'h00, 8'h30, 8'h50, 6'h04);
    run(subtract_with_borrow_to_work, 8'h21, 8'h00, 8'h30, 8'h10, 6'h00);
    run(subtract_with_borrow_to_work, 8'h22, 8'h00, 8'h01, 8'h80, 6'h04);
    run(subtract_with_borrow_to_work, 8'h23, 8'h00, 8'h30, 8'h30, 6'h05);
    run(subtract_with_borrow_imm_to_work, 8'h24, 8'h05, 8'h77, 8'h05, 6'h04);
    run(subtract_with_borrow_imm_to_work, 8'h24, 8'hFF, 8'h00, 8'h00, 6'h00);
    run(subtract_with_borrow_to_memory, 8'h25, 8'h00, 8'h01, 8'h00, 6'h00);
    run(subtract_with_borrow_to_memory, 8'h26, 8'h00, 8'h0F, 8'hF0, 6'h3C);
    run(decrement_skip_if_null, 8'h30, 8'h00, 8'h01, 8'h55, 6'h2A);
    run(decrement_skip_if_null, 8'h31, 8'h00, 8'h00, 8'h55, 6'h15);
    run(decrement_skip_if_null, 8'hFF, 8'h00, 8'h10, 8'h55, 6'h00);
    run(decrement_to_work_skip_if_null, 8'h33, 8'h00, 8'h01, 8'h77, 6'h15);
    run(decrement_to_work_skip_if_null, 8'h00, 8'h00, 8'h80, 8'h77, 6'h2A);
    // reset while an instruction runs: its write is dropped and the core idles
    mem_u.mem_ff[8'h40] = 8'h01;
    @(posedge clock_i);
    req_valid <= 1'b1;
    req <= '{decrement_skip_if_null, 8'h40, 8'h00};
    @(posedge clock_i);
    req_valid <= 1'b0;
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("mid_rst_ready", {7'h00, ready_o}, 8'h01);
    check("mid_rst_skip", {7'h00, skip_o}, 8'h00);
    check("mid_rst_mem", mem_u.mem_ff[8'h40], 8'h01);
    check("mid_rst_work", work_o, WORK_RST);
    // register map: work, flags with upper bits zero, unmapped reads zero
    reg_write(REG_WORK_OFS, 8'h3C);
    reg_read(REG_WORK_OFS, rv);
    check("reg_work", rv, 8'h3C);
    reg_write(REG_FLAGS_OFS, 8'hFF);
    reg_read(REG_FLAGS_OFS, rv);
    check("reg_flags", rv, 8'h3F);
    @(negedge clock_i);
    check("rdata_gone", reg_rdata_o, 8'h00);
    reg_write(4'h8, 8'hA5);
    reg_read(4'h8, rv);
    check("reg_unmapped", rv, 8'h00);
    tally_and_finish();
  end
endmodule : rotate_subtract_skip_datapath_tb
